// >>> logic/uafic_top.sv
// Uart fifo control, interrupt identification and apb register slave
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "uafic_map.svh"
module uafic_top
#(
	parameter int DEPTH = 16,
	parameter int TX_HOLDING_EMPTY_DELAY_CYCLES = (`UAFIC_TX_HOLDING_EMPTY_DELAY_NS + `UAFIC_CLK_PERIOD_NS - 1) / `UAFIC_CLK_PERIOD_NS
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire uafic_pkg::uafic_modem_type modem_pins,
	input wire uafic_pkg::uafic_char_type rx_char,
	output logic rx_char_ready,
	output uafic_pkg::uafic_char_type tx_char,
	input wire logic tx_char_ready,
	input wire logic line_err_pending,
	input wire logic char_timeout_pending,
	output logic fifo_enable,
	output logic irq
);
	localparam int CW = $clog2(DEPTH+1);
	localparam uafic_pkg::uafic_state_type RESET_STATE = '{tx_holding_empty_state: uafic_pkg::UAFIC_THR_IDLE,
		trig: `UAFIC_RST_TRIG, default: '0};

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (DEPTH < `UAFIC_MIN_DEPTH)
	begin : g_depth_check
		$error("uafic_top DEPTH below sixteen characters");
	end
	if (TX_HOLDING_EMPTY_DELAY_CYCLES < 1 || TX_HOLDING_EMPTY_DELAY_CYCLES > 65535)
	begin : g_delay_check
		$error("uafic_top TX_HOLDING_EMPTY_DELAY_CYCLES out of range");
	end

	uafic_pkg::uafic_state_type s;
	uafic_pkg::uafic_state_type n;
	logic setup;
	logic access;
	logic wr_data;
	logic wr_fcr;
	logic wr_status;
	logic wr_mask;
	logic rd_data;
	logic rd_ident;
	logic rd_modem;
	logic en_toggle;
	logic rx_flush;
	logic tx_flush;
	logic [CW-1:0] rx_count;
	logic [CW-1:0] tx_count;
	logic [7:0] rx_head;
	logic tx_empty;
	logic rx_data_available;
	logic [3:0] ident;
	logic [3:0] lvl;
	logic [3:0] prev;
	logic [3:0] delta_set;
	logic [2:0] events;

	function automatic logic reg_mapped(input logic [31:0] a);
		return a == `UAFIC_ADDR_DATA || a == `UAFIC_ADDR_FIFO_CONTROL || a == `UAFIC_ADDR_MODEM_STATUS ||
			a == `UAFIC_ADDR_IRQ_STATUS || a == `UAFIC_ADDR_IRQ_MASK;
	endfunction

	function automatic logic [4:0] trig_chars(input logic [1:0] t);
		case (t)
			2'h0: return `UAFIC_TRIG_LVL0;
			2'h1: return `UAFIC_TRIG_LVL1;
			2'h2: return `UAFIC_TRIG_LVL2;
			default: return `UAFIC_TRIG_LVL3;
		endcase
	endfunction

	// ----------------------------------------
	// Apb decode
	// ----------------------------------------
	// Zero wait states: read data is captured in the setup phase
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign pready = 1'b1;
	assign pslverr = access && !reg_mapped(paddr);
	assign prdata = s.rdata;
	assign wr_data = access && pwrite && paddr == `UAFIC_ADDR_DATA;
	assign wr_fcr = access && pwrite && paddr == `UAFIC_ADDR_FIFO_CONTROL;
	assign wr_status = access && pwrite && paddr == `UAFIC_ADDR_IRQ_STATUS;
	assign wr_mask = access && pwrite && paddr == `UAFIC_ADDR_IRQ_MASK;
	assign rd_data = access && !pwrite && paddr == `UAFIC_ADDR_DATA;
	assign rd_ident = access && !pwrite && paddr == `UAFIC_ADDR_FIFO_CONTROL;
	assign rd_modem = access && !pwrite && paddr == `UAFIC_ADDR_MODEM_STATUS;

	// ----------------------------------------
	// Fifo control
	// ----------------------------------------
	assign en_toggle = wr_fcr && (pwdata[`UAFIC_FCR_ENABLE] != s.fifo_en);
	assign rx_flush = en_toggle || (wr_fcr && pwdata[`UAFIC_FCR_ENABLE] && pwdata[`UAFIC_FCR_RX_FLUSH]);
	assign tx_flush = en_toggle || (wr_fcr && pwdata[`UAFIC_FCR_ENABLE] && pwdata[`UAFIC_FCR_TX_FLUSH]);

	uafic_fifo
	#(
		.WIDTH(8),
		.DEPTH(DEPTH)
	)
	u_rx_fifo
	(
		.clk_sys(clk_sys),
		.reset(reset),
		.flush(rx_flush),
		.push_valid(rx_char.valid),
		.push_data(rx_char.data),
		.push_ready(rx_char_ready),
		.pop_valid(),
		.pop_data(rx_head),
		.pop_ready(rd_data),
		.count(rx_count)
	);

	uafic_fifo
	#(
		.WIDTH(8),
		.DEPTH(DEPTH)
	)
	u_tx_fifo
	(
		.clk_sys(clk_sys),
		.reset(reset),
		.flush(tx_flush),
		.push_valid(wr_data),
		.push_data(pwdata[7:0]),
		.push_ready(),
		.pop_valid(tx_char.valid),
		.pop_data(tx_char.data),
		.pop_ready(tx_char_ready),
		.count(tx_count)
	);

	assign tx_empty = (tx_count == '0);
	assign fifo_enable = s.fifo_en;
	assign irq = s.irq;
	// A disabled fifo behaves as trigger level one
	assign rx_data_available = rx_count >= CW'(trig_chars(s.fifo_en ? s.trig : 2'h0));

	// ----------------------------------------
	// Modem inputs
	// ----------------------------------------
	assign lvl = s.msync2;
	assign prev = s.mprev;
	// Priming hides the reset-time jump of the synchroniser chain
	assign delta_set = s.prime[2] ? {lvl[3] ^ prev[3], lvl[2] & ~prev[2], lvl[1:0] ^ prev[1:0]} : 4'h0;

	// ----------------------------------------
	// Interrupt identification
	// ----------------------------------------
	always_comb
	begin
		if (line_err_pending)
		begin
			ident = `UAFIC_IDENT_LINE;
		end
		else if (rx_data_available)
		begin
			ident = `UAFIC_IDENT_RDA;
		end
		else if (char_timeout_pending)
		begin
			ident = `UAFIC_IDENT_CTI;
		end
		else if (s.tx_holding_empty_state == uafic_pkg::UAFIC_THR_PEND)
		begin
			ident = `UAFIC_IDENT_TX_HOLDING_EMPTY;
		end
		else if (s.mdelta != 4'h0)
		begin
			ident = `UAFIC_IDENT_MODEM;
		end
		else
		begin
			ident = `UAFIC_IDENT_NONE;
		end
	end

	assign events = {s.mdelta == 4'h0 && delta_set != 4'h0,
		n.tx_holding_empty_state == uafic_pkg::UAFIC_THR_PEND && s.tx_holding_empty_state != uafic_pkg::UAFIC_THR_PEND,
		rx_data_available && !s.rda_prev};

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		n = s;
		if (wr_fcr && pwdata[`UAFIC_FCR_ENABLE])
		begin
			n.trig = pwdata[`UAFIC_FCR_TRIG_MSB:`UAFIC_FCR_TRIG_LSB];
		end
		if (wr_fcr)
		begin
			n.fifo_en = pwdata[`UAFIC_FCR_ENABLE];
		end
		n.held_two = s.held_two || (tx_count >= CW'(2));
		case (s.tx_holding_empty_state)
			uafic_pkg::UAFIC_THR_IDLE:
			begin
				if (tx_empty && !wr_data && s.held_two)
				begin
					n.tx_holding_empty_state = uafic_pkg::UAFIC_THR_PEND;
					n.held_two = 1'b0;
				end
				else if (tx_empty && !wr_data)
				begin
					n.tx_holding_empty_state = uafic_pkg::UAFIC_THR_DELAY;
					n.tx_holding_empty_cnt = 16'(TX_HOLDING_EMPTY_DELAY_CYCLES - 1);
				end
			end
			uafic_pkg::UAFIC_THR_DELAY:
			begin
				if (!tx_empty || wr_data)
				begin
					n.tx_holding_empty_state = uafic_pkg::UAFIC_THR_IDLE;
				end
				else if (s.tx_holding_empty_cnt == 16'h0000)
				begin
					n.tx_holding_empty_state = uafic_pkg::UAFIC_THR_PEND;
					n.held_two = 1'b0;
				end
				else
				begin
					n.tx_holding_empty_cnt = s.tx_holding_empty_cnt - 16'h0001;
				end
			end
			uafic_pkg::UAFIC_THR_PEND:
			begin
				if (wr_data || !tx_empty)
				begin
					n.tx_holding_empty_state = uafic_pkg::UAFIC_THR_IDLE;
				end
				else if (rd_ident && s.rdata[3:0] == `UAFIC_IDENT_TX_HOLDING_EMPTY)
				begin
					n.tx_holding_empty_state = uafic_pkg::UAFIC_THR_DONE;
				end
			end
			uafic_pkg::UAFIC_THR_DONE:
			begin
				if (wr_data || !tx_empty)
				begin
					n.tx_holding_empty_state = uafic_pkg::UAFIC_THR_IDLE;
				end
			end
			default:
			begin
				n.tx_holding_empty_state = uafic_pkg::UAFIC_THR_IDLE;
			end
		endcase
		n.msync1 = modem_pins;
		n.msync2 = s.msync1;
		n.mprev = s.msync2;
		n.prime = {s.prime[1:0], 1'b1};
		// New change wins over the clearing read
		n.mdelta = (rd_modem ? 4'h0 : s.mdelta) | delta_set;
		n.rda_prev = rx_data_available;
		n.irq_status = (wr_status ? s.irq_status & ~pwdata[2:0] : s.irq_status) | events;
		if (wr_mask)
		begin
			n.irq_mask = pwdata[2:0];
		end
		n.irq = |(n.irq_status & n.irq_mask);
		if (setup && !pwrite)
		begin
			case (paddr)
				`UAFIC_ADDR_DATA: n.rdata = {24'h00_0000, rx_head};
				`UAFIC_ADDR_FIFO_CONTROL: n.rdata = {24'h00_0000, {2{s.fifo_en}}, 2'h0, ident};
				`UAFIC_ADDR_MODEM_STATUS: n.rdata = {24'h00_0000, lvl, s.mdelta};
				`UAFIC_ADDR_IRQ_STATUS: n.rdata = {29'h0000_0000, s.irq_status};
				`UAFIC_ADDR_IRQ_MASK: n.rdata = {29'h0000_0000, s.irq_mask};
				default: n.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			s <= RESET_STATE;
		end
		else
		begin
			s <= n;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence thr_write_s;
		wr_data && s.tx_holding_empty_state == uafic_pkg::UAFIC_THR_PEND;
	endsequence

	sequence tx_holding_empty_ident_read_s;
		rd_ident && !wr_data && tx_empty && s.tx_holding_empty_state == uafic_pkg::UAFIC_THR_PEND &&
			s.rdata[3:0] == `UAFIC_IDENT_TX_HOLDING_EMPTY;
	endsequence

	tx_holding_empty_ident_a: assert property (s.tx_holding_empty_state == uafic_pkg::UAFIC_THR_PEND && !line_err_pending && !rx_data_available &&
		!char_timeout_pending |-> ident == `UAFIC_IDENT_TX_HOLDING_EMPTY) else $error("holding-empty code wrong");
	tx_holding_empty_delay_load_a: assert property ($rose(s.tx_holding_empty_state == uafic_pkg::UAFIC_THR_DELAY) |->
		s.tx_holding_empty_cnt == 16'(TX_HOLDING_EMPTY_DELAY_CYCLES - 1)) else $error("holding-empty delay not loaded");
	tx_holding_empty_delay_end_a: assert property (s.tx_holding_empty_state == uafic_pkg::UAFIC_THR_DELAY &&
		n.tx_holding_empty_state == uafic_pkg::UAFIC_THR_PEND |-> s.tx_holding_empty_cnt == 16'h0000)
		else $error("holding-empty raised early");
	tx_holding_empty_fast_a: assert property (s.tx_holding_empty_state == uafic_pkg::UAFIC_THR_IDLE && tx_empty && !wr_data && s.held_two
		|=> s.tx_holding_empty_state == uafic_pkg::UAFIC_THR_PEND) else $error("holding-empty not immediate");
	tx_holding_empty_clear_a: assert property (thr_write_s or tx_holding_empty_ident_read_s |=> s.tx_holding_empty_state != uafic_pkg::UAFIC_THR_PEND)
		else $error("holding-empty not cleared");
	modem_change_a: assert property (s.prime[2] && (lvl[0] != prev[0] || lvl[3] != prev[3]) |=> s.mdelta != 4'h0)
		else $error("modem change missed");
	ri_fall_a: assert property (s.prime[2] && prev[2] && !lvl[2] && !s.mdelta[2] |=> !s.mdelta[2])
		else $error("ri fall raised modem");
	modem_read_a: assert property (rd_modem && delta_set == 4'h0 |=> s.mdelta == 4'h0 && ident != `UAFIC_IDENT_MODEM)
		else $error("modem read did not clear");
	enable_flush_a: assert property (en_toggle |=> rx_count == '0 && tx_count == '0)
		else $error("enable change did not flush");
	rx_flush_a: assert property (wr_fcr && pwdata[0] && pwdata[1] |=> rx_count == '0)
		else $error("receive flush failed");
	tx_flush_a: assert property (wr_fcr && pwdata[0] && pwdata[2] |=> tx_count == '0)
		else $error("transmit flush failed");
	trig_level_a: assert property (s.fifo_en && s.trig == 2'h3 |-> rx_data_available == (rx_count >= CW'(5'h0e)))
		else $error("trigger fourteen wrong");
	fcr_ignore_a: assert property (wr_fcr && !pwdata[0] |=> s.trig == $past(s.trig) && !s.fifo_en)
		else $error("control bits taken while disabled");

endmodule

// >>> logic/uafic_map.svh
// Register offsets, field positions, reset values and timing in nanoseconds of the uart fifo control
`ifndef UAFIC_MAP_SVH
`define UAFIC_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define UAFIC_ADDR_DATA 32'h4000_8000
`define UAFIC_ADDR_FIFO_CONTROL 32'h4000_8008
`define UAFIC_ADDR_MODEM_STATUS 32'h4000_8018
`define UAFIC_ADDR_IRQ_STATUS 32'h4000_8040
`define UAFIC_ADDR_IRQ_MASK 32'h4000_8044

// ----------------------------------------
// Fifo control fields
// ----------------------------------------
`define UAFIC_FCR_ENABLE 0
`define UAFIC_FCR_RX_FLUSH 1
`define UAFIC_FCR_TX_FLUSH 2
`define UAFIC_FCR_TRIG_MSB 7
`define UAFIC_FCR_TRIG_LSB 6
`define UAFIC_RST_TRIG 2'h0
`define UAFIC_TRIG_LVL0 5'h01
`define UAFIC_TRIG_LVL1 5'h04
`define UAFIC_TRIG_LVL2 5'h08
`define UAFIC_TRIG_LVL3 5'h0e
`define UAFIC_MIN_DEPTH 16

// ----------------------------------------
// Identification codes
// ----------------------------------------
`define UAFIC_IDENT_NONE 4'h1
`define UAFIC_IDENT_LINE 4'h6
`define UAFIC_IDENT_RDA 4'h4
`define UAFIC_IDENT_CTI 4'hc
`define UAFIC_IDENT_TX_HOLDING_EMPTY 4'h2
`define UAFIC_IDENT_MODEM 4'h0

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define UAFIC_EV_RDA 0
`define UAFIC_EV_TX_HOLDING_EMPTY 1
`define UAFIC_EV_MODEM 2

// ----------------------------------------
// Timing
// ----------------------------------------
`define UAFIC_CLK_PERIOD_NS 5
`define UAFIC_TX_HOLDING_EMPTY_DELAY_NS 40000

`endif

// >>> logic/uafic_pkg.sv
// Types shared by the uart fifo control design
package uafic_pkg;

	typedef enum logic [3:0]
	{
		UAFIC_THR_IDLE = 4'b0001,
		UAFIC_THR_DELAY = 4'b0010,
		UAFIC_THR_PEND = 4'b0100,
		UAFIC_THR_DONE = 4'b1000
	} uafic_tx_holding_empty_state_type;

	typedef struct packed
	{
		logic dcd;
		logic ri;
		logic dsr;
		logic cts;
	} uafic_modem_type;

	typedef struct packed
	{
		logic valid;
		logic [7:0] data;
	} uafic_char_type;

	typedef struct packed
	{
		uafic_tx_holding_empty_state_type tx_holding_empty_state;
		logic [15:0] tx_holding_empty_cnt;
		logic held_two;
		logic fifo_en;
		logic [1:0] trig;
		uafic_modem_type msync1;
		uafic_modem_type msync2;
		uafic_modem_type mprev;
		logic [2:0] prime;
		logic [3:0] mdelta;
		logic rda_prev;
		logic modem_prev;
		logic [2:0] irq_status;
		logic [2:0] irq_mask;
		logic irq;
		logic [31:0] rdata;
	} uafic_state_type;

endpackage

// >>> logic/uafic_fifo.sv
// Synchronous character fifo with flush, used for receive and transmit
`timescale 1ns/1ps
module uafic_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic flush,
	input wire logic push_valid,
	input wire logic [WIDTH-1:0] push_data,
	output logic push_ready,
	output logic pop_valid,
	output logic [WIDTH-1:0] pop_data,
	input wire logic pop_ready,
	output logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [CW-1:0] count;
	} uafic_fifo_state_type;

	uafic_fifo_state_type s;
	uafic_fifo_state_type n;
	logic push;
	logic pop;

	// Pointers wrap freely only for a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_depth_check
		$error("uafic_fifo DEPTH must be a power of two");
	end

	assign push_ready = (s.count != CW'(DEPTH));
	assign pop_valid = (s.count != '0);
	assign pop_data = s.mem[s.rptr];
	assign count = s.count;
	assign push = push_valid && push_ready;
	assign pop = pop_ready && pop_valid;

	always_comb
	begin
		n = s;
		// Flush beats a push or pop in the same cycle
		if (flush)
		begin
			n.wptr = '0;
			n.rptr = '0;
			n.count = '0;
		end
		else
		begin
			if (push)
			begin
				n.mem[s.wptr] = push_data;
				n.wptr = s.wptr + 1'b1;
			end
			if (pop)
			begin
				n.rptr = s.rptr + 1'b1;
			end
			n.count = s.count + CW'(push) - CW'(pop);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			s <= '0;
		end
		else
		begin
			s <= n;
		end
	end

endmodule

// >>> verif/uafic_peer.sv
// Remote serial device model on the character and modem side
`timescale 1ns/1ps
module uafic_peer
(
	input wire logic clk_sys,
	output uafic_pkg::uafic_char_type rx_char,
	input wire logic rx_char_ready,
	input wire uafic_pkg::uafic_char_type tx_char,
	output logic tx_char_ready,
	output uafic_pkg::uafic_modem_type modem_pins
);
	// ----------------------------------------
	// Peer behaviour
	// ----------------------------------------
	logic stall;

	initial
	begin
		stall = 1'b0;
		rx_char = 9'h0a5;
		tx_char_ready = 1'b0;
		modem_pins = 4'h0;
	end

	// Random slow accepts so the transmit side sees stalls too
	always @(posedge clk_sys)
		tx_char_ready <= !stall && ($urandom_range(3) != 0);

	// Data line shows the inverse once released, never a stale copy
	task automatic send(input logic [7:0] d);
		@(posedge clk_sys);
		rx_char <= {1'b1, d};
		@(posedge clk_sys);
		while (rx_char_ready !== 1'b1)
			@(posedge clk_sys);
		rx_char <= {1'b0, ~d};
	endtask

	task automatic set_modem(input uafic_pkg::uafic_modem_type m);
		@(posedge clk_sys);
		modem_pins <= m;
	endtask
endmodule

// >>> verif/tb.sv
// Self-checking bench for the uart fifo control block
`timescale 1ns/1ps
`include "uafic_map.svh"
module tb;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	localparam int dly = 20;
	localparam logic [31:0] a_dat = `UAFIC_ADDR_DATA;
	localparam logic [31:0] a_id = `UAFIC_ADDR_FIFO_CONTROL;
	localparam logic [31:0] a_ms = `UAFIC_ADDR_MODEM_STATUS;
	localparam logic [31:0] a_st = `UAFIC_ADDR_IRQ_STATUS;
	localparam logic [31:0] a_mk = `UAFIC_ADDR_IRQ_MASK;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0000_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	uafic_pkg::uafic_modem_type modem_pins;
	uafic_pkg::uafic_char_type rx_char;
	uafic_pkg::uafic_char_type tx_char;
	logic rx_char_ready;
	logic tx_char_ready;
	logic line_err_pending = 1'b0;
	logic char_timeout_pending = 1'b0;
	logic fifo_enable;
	logic irq;
	int mismatches = 0;
	int checked = 0;
	logic [32:0] rd_q[$];
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	int lv[4] = '{1, 4, 8, 14};
	logic [3:0] mv;
	logic [3:0] ev;
	int b;
	logic [31:0] seed_val;

	always #2.5 clk_sys = ~clk_sys;

	uafic_top #(.DEPTH(16), .TX_HOLDING_EMPTY_DELAY_CYCLES(dly)) dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .modem_pins(modem_pins), .rx_char(rx_char), .rx_char_ready(rx_char_ready),
		.tx_char(tx_char), .tx_char_ready(tx_char_ready), .line_err_pending(line_err_pending),
		.char_timeout_pending(char_timeout_pending), .fifo_enable(fifo_enable), .irq(irq));

	uafic_peer u_peer (.clk_sys(clk_sys), .rx_char(rx_char), .rx_char_ready(rx_char_ready), .tx_char(tx_char),
		.tx_char_ready(tx_char_ready), .modem_pins(modem_pins));

	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wrap_up;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	function automatic logic [32:0] idv(input logic [3:0] c);
		return {25'h0, 4'hc, c};
	endfunction

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [32:0] exp);
		rd_q.push_back(exp);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic send_rx;
		logic [7:0] d;
		d = 8'($urandom);
		rx_q.push_back(d);
		u_peer.send(d);
	endtask

	task automatic send_tx;
		logic [7:0] d;
		d = 8'($urandom);
		tx_q.push_back(d);
		apb(1'b1, a_dat, {24'h0, d});
	endtask

	// Read results are compared against the oldest note
	always @(posedge clk_sys)
		if (psel && penable && pready && !pwrite)
		begin
			if (rd_q.size() == 0)
				chk("read note", 33'h0_0000_0000, 33'h0_0000_0001);
			else
				chk($sformatf("read %h", paddr), rd_q.pop_front(), {pslverr, prdata});
		end

	always @(posedge clk_sys)
		if (tx_char.valid === 1'b1 && tx_char_ready === 1'b1)
		begin
			if (tx_q.size() == 0)
				chk("tx note", 33'h0_0000_0000, 33'h0_0000_0001);
			else
				chk("tx data", {25'h0, tx_q.pop_front()}, {25'h0, tx_char.data});
		end

	initial
	begin
		#50000;
		mismatches++;
		wrap_up();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		seed_val = $urandom(32'hf7e7_7e1a);
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		chk("fifo_enable", 33'h0, {32'h0, fifo_enable});
		chk("rx_char_ready", 33'h1, {32'h0, rx_char_ready});
		chk("tx valid", 33'h0, {32'h0, tx_char.valid});
		rd(a_mk, 33'h0_0000_0000);
		rd(a_id, 33'h0_0000_0001);
		repeat (dly + 10) @(posedge clk_sys);
		rd(a_id, 33'h0_0000_0002);
		rd(a_id, 33'h0_0000_0001);
		rd(32'h4000_8100, 33'h1_0000_0000);
		apb(1'b1, a_id, 32'h0000_00c0);
		rd(a_id, 33'h0_0000_0001);
		apb(1'b1, a_id, 32'h0000_0001);
		@(posedge clk_sys);
		chk("fifo_enable", 33'h1, {32'h0, fifo_enable});
		// Trigger levels, flushing the receive side before each
		for (int t = 0; t < 4; t++)
		begin
			apb(1'b1, a_id, {24'h0, t[1:0], 6'h03});
			rx_q.delete();
			for (int n = 1; n < lv[t]; n++)
				send_rx();
			repeat (3) @(posedge clk_sys);
			rd(a_id, idv(4'h1));
			send_rx();
			repeat (3) @(posedge clk_sys);
			rd(a_id, idv(4'h4));
			rd(a_dat, {25'h0, rx_q[0]});
			void'(rx_q.pop_front());
			rd(a_id, idv(4'h1));
		end
		apb(1'b1, a_id, 32'h0000_0001);
		rd(a_id, idv(4'h4));
		apb(1'b1, a_id, 32'h0000_0000);
		rx_q.delete();
		rd(a_id, 33'h0_0000_0001);
		apb(1'b1, a_id, 32'h0000_0001);
		// Interrupt status, mask and level output
		apb(1'b1, a_st, 32'h0000_0007);
		apb(1'b1, a_mk, 32'h0000_0001);
		send_rx();
		repeat (3) @(posedge clk_sys);
		chk("irq", 33'h1, {32'h0, irq});
		rd(a_st, 33'h0_0000_0001);
		apb(1'b1, a_mk, 32'h0000_0000);
		@(posedge clk_sys);
		chk("irq", 33'h0, {32'h0, irq});
		apb(1'b1, a_mk, 32'h0000_0001);
		@(posedge clk_sys);
		chk("irq", 33'h1, {32'h0, irq});
		apb(1'b1, a_st, 32'h0000_0001);
		@(posedge clk_sys);
		chk("irq", 33'h0, {32'h0, irq});
		rd(a_dat, {25'h0, rx_q.pop_front()});
		// Holding-empty with and without the two-character history
		u_peer.stall <= 1'b1;
		repeat (3) send_tx();
		rd(a_id, idv(4'h1));
		u_peer.stall <= 1'b0;
		repeat (20) @(posedge clk_sys);
		chk("tx valid", 33'h0, {32'h0, tx_char.valid});
		rd(a_id, idv(4'h2));
		rd(a_id, idv(4'h1));
		u_peer.stall <= 1'b1;
		repeat (2) send_tx();
		apb(1'b1, a_id, 32'h0000_0005);
		tx_q.delete();
		@(posedge clk_sys);
		chk("tx valid", 33'h0, {32'h0, tx_char.valid});
		rd(a_id, idv(4'h2));
		u_peer.stall <= 1'b0;
		send_tx();
		rd(a_id, idv(4'h1));
		repeat (dly + 10) @(posedge clk_sys);
		rd(a_id, idv(4'h2));
		rd(a_id, idv(4'h1));
		// Modem inputs, each rising then falling
		mv = 4'h0;
		for (int i = 0; i < 8; i++)
		begin
			b = i % 4;
			mv[b] = ~mv[b];
			u_peer.set_modem(mv);
			repeat (6) @(posedge clk_sys);
			ev = (b == 2 && i >= 4) ? 4'h0 : 4'h1 << b;
			rd(a_id, idv((ev == 4'h0) ? 4'h1 : 4'h0));
			rd(a_ms, {25'h0, mv, ev});
			rd(a_ms, {25'h0, mv, 4'h0});
		end
		// Priority among pending sources
		send_rx();
		line_err_pending <= 1'b1;
		char_timeout_pending <= 1'b1;
		rd(a_id, idv(4'h6));
		line_err_pending <= 1'b0;
		rd(a_id, idv(4'h4));
		rd(a_dat, {25'h0, rx_q.pop_front()});
		rd(a_id, idv(4'hc));
		char_timeout_pending <= 1'b0;
		rd(a_id, idv(4'h1));
		repeat (4) @(posedge clk_sys);
		wrap_up();
	end
endmodule
